// ### design/ufb_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "ufb_defs.svh"
module ufb_ctrl (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Core special-function bus
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Link-side events
	input wire logic bus_reset_i,
	input wire logic sof_i,
	input wire logic frame_tick_i,
	input wire logic [10:0] frame_num_i,
	input wire logic [15:0] ep_event_i,
	// Payload stream towards the link
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [7:0] tx_data_o,
	// State
	output logic enhanced_o,
	output logic [7:0] address_enable_o,
	output logic all_endpoints_enable_o,
	output logic [15:0] mode_bytes_o,
	output logic resume_o,
	output logic ep2_buf_sel_o,
	output logic cfg_error_o
);
	logic [7:0] cmd_q;
	logic [1:0] idx_q;
	logic enh_q;
	logic [7:0] addr_q;
	logic epen_q;
	logic [7:0] mode_lo_q;
	logic [15:0] mode_q;
	logic resume_q;
	logic [3:0] sel_q;
	logic [7:0] cfg_q [16];
	logic [15:0] evt_q;
	logic brst_q;
	logic susp_q;
	logic suspended_q;
	logic [1:0] miss_q;
	logic [1:0] ep2_full_q;
	logic ep2_wsel_q;
	logic ep2_rsel_q;
	logic [7:0] rdata_q;
	logic err_q;
	logic bufint_q;
	logic [9:0] len_q;
	ufb_pkg::ufb_phase_type ph_q;
	logic fifo_ready;
	logic fifo_ovalid;
	logic [7:0] fifo_odata;

	// Buffer size in bytes from a size code, zero for an illegal code.
	function automatic logic [10:0] size_of(input logic [3:0] code,
		input logic iso);
		logic [10:0] r;
		r = 11'h_000;
		if (!iso)
			r = (code < 4'h_4) ? (11'h_008 << code) : 11'h_000; // [RULE10] [RULE8]
		else
			case (code) // [RULE10]
				4'h_0: r = 11'h_010;
				4'h_1: r = 11'h_020;
				4'h_2: r = 11'h_030;
				4'h_3: r = 11'h_040;
				4'h_4: r = 11'h_060;
				4'h_5: r = 11'h_080;
				4'h_6: r = 11'h_0A0;
				4'h_7: r = 11'h_0C0;
				4'h_8: r = 11'h_100;
				4'h_9: r = 11'h_140;
				4'h_A: r = 11'h_180;
				4'h_B: r = `UFB_MAX_BUF;
				default: r = 11'h_000;
			endcase
		return r;
	endfunction : size_of

	// Endpoint two max packet for the current mode and direction.
	function automatic logic [10:0] ep2_max(input logic [1:0] m,
		input logic in_dir);
		logic [10:0] r;
		r = 11'h_040;
		case (m) // [RULE4]
			2'h_1: r = in_dir ? 11'h_000 : 11'h_080;
			2'h_2: r = in_dir ? 11'h_080 : 11'h_000;
			default: r = 11'h_040;
		endcase
		return r;
	endfunction : ep2_max

	wire wr_cmd = sfr_wr_i && (sfr_addr_i == `UFB_CMD_ADDR); // [RULE1]
	wire wr_dat = sfr_wr_i && (sfr_addr_i == `UFB_DATA_ADDR);
	wire rd_dat = sfr_rd_i && (sfr_addr_i == `UFB_DATA_ADDR);
	wire is_cfg = (sfr_wdata_i[7:4] == `UFB_CMD_SETCFG); // [RULE2]
	wire [7:0] sel_max = enh_q ? `UFB_CMD_SELMAX_ENH : `UFB_CMD_SELMAX_DEF;
	wire is_sel = (cmd_q <= sel_max); // [RULE12]
	wire is_last = (cmd_q[7:4] == `UFB_CMD_LASTST)
		&& (enh_q || cmd_q[3:0] <= 4'h_5); // [RULE11]
	wire is_epst = (cmd_q[7:4] == `UFB_CMD_EPST)
		&& (enh_q || cmd_q[3:0] <= 4'h_5); // [RULE11]
	wire fn_en = addr_q[`UFB_BIT_ADDR_EN];
	wire sel_ep2 = !enh_q && (sel_q[3:1] == 3'h_2);
	wire [10:0] sel_max_pkt = enh_q
		? size_of(cfg_q[sel_q][6:3], cfg_q[sel_q][2:1] == `UFB_TYPE_ISO)
		: (sel_ep2 ? ep2_max(mode_q[7:6], sel_q[0]) : `UFB_DEF_MAX); // [RULE3]
	wire [10:0] cfg_size = size_of(sfr_wdata_i[6:3],
		sfr_wdata_i[2:1] == `UFB_TYPE_ISO);
	wire cfg_bad = (cfg_size == 11'h_000) || (cfg_size > `UFB_MAX_BUF); // [RULE6]
	wire [10:0] pool_left = `UFB_POOL_BYTES - `UFB_EP0_RESV; // [RULE7]
	wire sof_miss = frame_tick_i && !sof_i;
	wire [7:0] int_b0 = {susp_q, brst_q, evt_q[5:0]};
	wire [1:0] int_last = enh_q ? 2'h_3 : 2'h_1; // [RULE14]
	wire pay_wr = wr_dat && cmd_q == `UFB_CMD_BUF && ph_q == ufb_pkg::UFB_PAYLOAD;
	wire push_ok = pay_wr && fifo_ready && len_q != 10'h_000;
	// A dropped byte breaks the packet, so the error is kept until reset or the next configuration data write.
	wire pay_drop = pay_wr && (len_q == 10'h_000 || !fifo_ready);

	logic [7:0] rd_val;
	always_comb
	begin
		rd_val = 8'h_00;
		if (cmd_q == `UFB_CMD_INTRD)
			case (idx_q) // [RULE14]
				2'h_0: rd_val = int_b0;
				2'h_1: rd_val = 8'h_00;
				2'h_2: rd_val = enh_q ? evt_q[13:6] : 8'h_00;
				default: rd_val = enh_q ? {6'h_00, evt_q[15:14]} : 8'h_00;
			endcase
		else if (cmd_q == `UFB_CMD_FRAME)
			rd_val = idx_q[0] ? {5'h_00, frame_num_i[10:8]}
				: frame_num_i[7:0]; // [RULE13]
		else if (is_sel)
			rd_val = {7'h_00, sel_ep2 ? ep2_full_q[ep2_rsel_q] : evt_q[sel_q]};
		else if (is_epst)
			rd_val = {1'b0, ep2_full_q, 5'h_00};
		else if (cmd_q == `UFB_CMD_BUF)
			rd_val = (ph_q == ufb_pkg::UFB_LEN_HI) ? {5'h_00, sel_max_pkt[10:8]}
				: sel_max_pkt[7:0]; // [RULE18]
		else if (is_last)
			rd_val = {7'h_00, evt_q[cmd_q[3:0]]};
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			cmd_q <= 8'h_FF;
			idx_q <= 2'h_0;
			enh_q <= 1'b0; // [RULE2]
			addr_q <= 8'h_00;
			epen_q <= 1'b0;
			mode_lo_q <= 8'h_00;
			mode_q <= 16'h_0000;
			resume_q <= 1'b0;
			sel_q <= 4'h_0;
			evt_q <= 16'h_0000;
			brst_q <= 1'b0;
			susp_q <= 1'b0;
			suspended_q <= 1'b0;
			miss_q <= 2'h_0;
			ep2_full_q <= 2'h_0;
			ep2_wsel_q <= 1'b0;
			ep2_rsel_q <= 1'b0;
			rdata_q <= 8'h_00;
			err_q <= 1'b0;
			bufint_q <= 1'b0;
			len_q <= 10'h_000;
			ph_q <= ufb_pkg::UFB_IDLE;
		end
		else
		begin
			resume_q <= 1'b0;
			if (wr_cmd)
			begin
				cmd_q <= sfr_wdata_i; // [RULE20]
				idx_q <= 2'h_0;
				ph_q <= (sfr_wdata_i == `UFB_CMD_BUF) ? ufb_pkg::UFB_LEN_HI
					: ufb_pkg::UFB_IDLE;
				if (sfr_wdata_i <= sel_max)
					sel_q <= sfr_wdata_i[3:0]; // [RULE12]
				if (is_cfg)
					enh_q <= 1'b1; // [RULE2]
				if (sfr_wdata_i == `UFB_CMD_RESUME)
					resume_q <= 1'b1; // [RULE13]
				if (sfr_wdata_i == `UFB_CMD_BUFINT && enh_q)
					bufint_q <= 1'b1; // [RULE14]
				if (sfr_wdata_i == `UFB_CMD_VALID && sel_ep2)
				begin
					ep2_full_q[ep2_wsel_q] <= 1'b1;
					ep2_wsel_q <= !ep2_wsel_q; // [RULE5]
				end
				if (sfr_wdata_i == `UFB_CMD_CLEAR && sel_ep2)
				begin
					ep2_full_q[ep2_rsel_q] <= 1'b0;
					ep2_rsel_q <= !ep2_rsel_q; // [RULE5]
				end
			end
			if (wr_dat)
			begin
				idx_q <= idx_q + 2'h_1;
				if (cmd_q == `UFB_CMD_ADDREN)
					addr_q <= sfr_wdata_i; // [RULE16]
				if (cmd_q == `UFB_CMD_EPEN && fn_en)
					epen_q <= sfr_wdata_i[0]; // [RULE17]
				if (cmd_q == `UFB_CMD_SETMODE && idx_q == 2'h_0)
					mode_lo_q <= sfr_wdata_i;
				if (cmd_q == `UFB_CMD_SETMODE && idx_q == 2'h_1)
					mode_q <= {sfr_wdata_i, mode_lo_q}; // [RULE15]
				if (cmd_q[7:4] == `UFB_CMD_SETCFG)
				begin
					cfg_q[cmd_q[3:0]] <= sfr_wdata_i;
					err_q <= cfg_bad || pool_left < cfg_size; // [RULE6]
				end
				if (cmd_q == `UFB_CMD_BUF)
					case (ph_q) // [RULE18]
						ufb_pkg::UFB_LEN_HI:
						begin
							len_q[9:8] <= enh_q ? sfr_wdata_i[1:0] : 2'h_0;
							ph_q <= ufb_pkg::UFB_LEN_LO;
						end
						ufb_pkg::UFB_LEN_LO:
						begin
							len_q[7:0] <= sfr_wdata_i;
							ph_q <= ufb_pkg::UFB_PAYLOAD;
							if ({len_q[9:8], sfr_wdata_i} > sel_max_pkt[9:0])
								err_q <= 1'b1; // [RULE9]
						end
						default: ph_q <= ph_q;
					endcase
			end
			if (push_ok)
				len_q <= len_q - 10'h_001; // [RULE9]
			if (pay_drop)
				err_q <= 1'b1; // [RULE9]
			if (rd_dat)
			begin
				rdata_q <= rd_val;
				idx_q <= (idx_q == int_last && cmd_q == `UFB_CMD_INTRD)
					? idx_q : idx_q + 2'h_1;
				if (cmd_q == `UFB_CMD_BUF && ph_q != ufb_pkg::UFB_PAYLOAD)
					ph_q <= (ph_q == ufb_pkg::UFB_LEN_HI) ? ufb_pkg::UFB_LEN_LO
						: ufb_pkg::UFB_PAYLOAD;
			end
			// Hardware set wins over read-to-clear in the same cycle.
			evt_q <= (is_last && rd_dat)
				? ((evt_q & ~(16'h_0001 << cmd_q[3:0])) | ep_event_i)
				: (evt_q | ep_event_i);
			brst_q <= bus_reset_i
				|| (brst_q && !(rd_dat && cmd_q == `UFB_CMD_INTRD && idx_q == 2'h_0)); // [RULE19]
			if (sof_i)
				miss_q <= 2'h_0;
			else if (sof_miss && miss_q != `UFB_SOF_MISS)
				miss_q <= miss_q + 2'h_1;
			if (sof_miss && miss_q == `UFB_SOF_MISS - 2'h_1 && !suspended_q)
			begin
				suspended_q <= 1'b1;
				susp_q <= 1'b1; // [RULE19]
			end
			else if (sof_i && suspended_q)
			begin
				suspended_q <= 1'b0;
				susp_q <= 1'b1; // [RULE19]
			end
			else if (rd_dat && cmd_q == `UFB_CMD_INTRD && idx_q == 2'h_0)
				susp_q <= 1'b0; // [RULE19]
			if (bus_reset_i)
			begin
				addr_q <= 8'h_80; // [RULE16]
				epen_q <= 1'b0;
			end
		end
	end

	ufb_fifo #(
		.WIDTH(8),
		.DEPTH(`UFB_FIFO_DEPTH)
	) u_fifo (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.in_valid_i(pay_wr && len_q != 10'h_000),
		.in_ready_o(fifo_ready),
		.in_data_i(sfr_wdata_i),
		.out_valid_o(fifo_ovalid),
		.out_ready_i(tx_ready_i && !tx_valid_o),
		.out_data_o(fifo_odata)
	);

	// The stream stage is registered so the port comes from a flop.
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h_00;
		end
		else if (!tx_valid_o || tx_ready_i)
		begin
			tx_valid_o <= fifo_ovalid && tx_ready_i && !tx_valid_o;
			tx_data_o <= fifo_odata;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			sfr_rdata_o <= 8'h_00;
			enhanced_o <= 1'b0;
			address_enable_o <= 8'h_00;
			all_endpoints_enable_o <= 1'b0;
			mode_bytes_o <= 16'h_0000;
			resume_o <= 1'b0;
			ep2_buf_sel_o <= 1'b0;
			cfg_error_o <= 1'b0;
		end
		else
		begin
			sfr_rdata_o <= rdata_q;
			enhanced_o <= enh_q;
			address_enable_o <= addr_q;
			all_endpoints_enable_o <= epen_q && fn_en; // [RULE17]
			mode_bytes_o <= mode_q;
			resume_o <= resume_q;
			ep2_buf_sel_o <= ep2_wsel_q;
			cfg_error_o <= err_q;
		end
	end
endmodule : ufb_ctrl
`default_nettype wire

// ### design/ufb_defs.svh
// Operation
// RULE1 - Core writes command, then data bytes through port
// RULE2 - Default mode after reset; B0-BF enters enhanced
// RULE3 - Default endpoints zero and one: 16 bytes
// RULE4 - Endpoint two mode selects type and size
// RULE5 - Endpoint two double buffered, alternating automatically
// RULE6 - Enhanced pools 1 kB each, 504 per buffer
// RULE7 - Eight bytes per pool reserved for endpoint zero
// RULE8 - Non-isochronous endpoints limited to 64 bytes
// RULE9 - Each buffer holds exactly one packet
// RULE10 - Four-bit size code decodes to byte counts
// RULE11 - Per-endpoint codes are base plus endpoint index
// RULE12 - Select endpoint code is index, optional status
// RULE13 - F5 reads frame number, F6 requests resume
// RULE14 - EC accepted enhanced; interrupt read four bytes
// RULE15 - Set mode takes two bytes, then applies
// RULE16 - D0 loads address and enable; bus reset clears; code loads 80 on bus reset, address zero with enable set
// RULE17 - D8 bit zero enables endpoints when function enabled
// RULE18 - Buffer data: length high, length low, payload
// RULE19 - Suspend change after three missed frames; read clears
// RULE20 - Data bytes follow the latest command code
`ifndef UFB_DEFS_SVH
`define UFB_DEFS_SVH
`define UFB_CMD_ADDR 8'h_FC
`define UFB_DATA_ADDR 8'h_FD
`define UFB_CMD_SETCFG 4'h_B
`define UFB_CMD_LASTST 4'h_4
`define UFB_CMD_EPST 4'h_8
`define UFB_CMD_SELMAX_DEF 8'h_05
`define UFB_CMD_SELMAX_ENH 8'h_0F
`define UFB_CMD_ADDREN 8'h_D0
`define UFB_CMD_EPEN 8'h_D8
`define UFB_CMD_SETMODE 8'h_F3
`define UFB_CMD_INTRD 8'h_F4
`define UFB_CMD_FRAME 8'h_F5
`define UFB_CMD_RESUME 8'h_F6
`define UFB_CMD_BUFINT 8'h_EC
`define UFB_CMD_BUF 8'h_F0
`define UFB_CMD_VALID 8'h_FA
`define UFB_CMD_CLEAR 8'h_F2
`define UFB_SOF_MISS 2'h_3
`define UFB_POOL_BYTES 11'h_400
`define UFB_EP0_RESV 11'h_008
`define UFB_MAX_BUF 11'h_1F8
`define UFB_NONISO_MAX 11'h_040
`define UFB_DEF_MAX 11'h_010
`define UFB_TYPE_ISO 2'h_2
`define UFB_BIT_ADDR_EN 7
`define UFB_BIT_INT_BRST 6
`define UFB_BIT_INT_SUSP 7
`define UFB_FIFO_DEPTH 4
`endif

// ### design/ufb_pkg.sv
package ufb_pkg;
	typedef enum logic [1:0]
	{
		UFB_IDLE = 2'b00,
		UFB_LEN_HI = 2'b01,
		UFB_LEN_LO = 2'b11,
		UFB_PAYLOAD = 2'b10
	} ufb_phase_type;
endpackage : ufb_pkg

// ### design/ufb_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ufb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end
endmodule : ufb_fifo
`default_nettype wire

// ### tb/ufb_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ufb_ctrl_monitor (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Watched ports
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic bus_reset_i,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic [7:0] tx_data_o,
	input wire logic enhanced_o,
	input wire logic [7:0] address_enable_o,
	input wire logic all_endpoints_enable_o,
	input wire logic [15:0] mode_bytes_o,
	input wire logic resume_o,
	input wire logic cfg_error_o
);
	logic [3:0] wr_q;
	logic [3:0] rd_q;
	logic [3:0] br_q;
	wire logic cmd_w = sfr_wr_i && sfr_addr_i == 8'h_FC;
	default clocking ck @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	// Histories let the source checks allow for the output latency.
	always_ff @(posedge mclk_i)
	begin
		wr_q <= srst_i ? 4'h_0 : {wr_q[2:0], sfr_wr_i};
		rd_q <= srst_i ? 4'h_0 : {rd_q[2:0], sfr_rd_i};
		br_q <= srst_i ? 4'h_0 : {br_q[2:0], bus_reset_i};
	end
	res_delay_a: assert property (cmd_w && sfr_wdata_i == 8'h_F6
		|-> ##2 resume_o) else $error("resume pulse late");
	res_single_a: assert property (resume_o |=> !resume_o)
		else $error("resume pulse too long");
	enh_keep_a: assert property (enhanced_o |=> enhanced_o)
		else $error("enhanced mode left");
	enh_entry_a: assert property (cmd_w && sfr_wdata_i[7:4] == 4'h_B
		|-> ##[1:4] enhanced_o) else $error("enhanced mode not entered");
	brst_addr_a: assert property (bus_reset_i
		|-> ##[1:4] address_enable_o == 8'h_80) else $error("bus reset address");
	ep_gate_a: assert property (all_endpoints_enable_o
		|-> address_enable_o[7]) else $error("endpoints on, function off");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i
		|=> tx_valid_o && $stable(tx_data_o)) else $error("stream byte lost");
	mode_src_a: assert property ($changed(mode_bytes_o) |-> |wr_q)
		else $error("mode bytes changed unasked");
	addr_src_a: assert property ($changed(address_enable_o)
		|-> |{wr_q, br_q}) else $error("address changed unasked");
	rd_hold_a: assert property (!sfr_rd_i && !(|rd_q)
		|=> $stable(sfr_rdata_o)) else $error("read data not held");
	cover property (resume_o);
	cover property ($rose(enhanced_o));
	cover property (tx_valid_o && tx_ready_i);
	cover property ($rose(cfg_error_o));
endmodule : ufb_ctrl_monitor
bind ufb_ctrl ufb_ctrl_monitor mon (.mclk_i(mclk_i), .srst_i(srst_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
	.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
	.bus_reset_i(bus_reset_i), .tx_valid_o(tx_valid_o),
	.tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .enhanced_o(enhanced_o),
	.address_enable_o(address_enable_o), .mode_bytes_o(mode_bytes_o),
	.all_endpoints_enable_o(all_endpoints_enable_o), .resume_o(resume_o),
	.cfg_error_o(cfg_error_o));
`default_nettype wire

// ### tb/ufb_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module ufb_link_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Payload stream, stalled on command
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic [7:0] tx_data_i,
	input wire logic stall_i,
	// Frame timing and receive count
	output logic sof_o,
	output logic frame_tick_o,
	output logic [10:0] frame_num_o,
	output logic [7:0] count_o,
	// Withholds start-of-frame tokens to force a suspend
	input wire logic drop_i
);
	logic [4:0] slot_q;
	logic [7:0] got[$];
	assign tx_ready_o = !stall_i;
	// A token every frame keeps the controller out of suspend.
	assign frame_tick_o = slot_q == 5'h_1F;
	assign sof_o = frame_tick_o && !drop_i;
	always @(posedge mclk_i)
	begin
		slot_q <= srst_i ? 5'h_00 : slot_q + 5'h_01;
		if (srst_i)
		begin
			frame_num_o <= 11'h_3A5;
			count_o <= 8'h_00;
			got.delete();
		end
		else
		begin
			frame_num_o <= frame_num_o + {10'h_000, frame_tick_o};
			if (tx_valid_i && tx_ready_o)
			begin
				got.push_back(tx_data_i);
				count_o <= count_o + 8'h_01;
			end
		end
	end
endmodule : ufb_link_model
`default_nettype wire

// ### tb/usb_fs_device_command_buffers_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module usb_fs_device_command_buffers_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic w = 1'b0;
	logic r = 1'b0;
	logic br = 1'b0;
	logic st = 1'b0;
	logic [7:0] a = 8'h_00;
	logic [7:0] d = 8'h_00;
	logic [7:0] pulses = 8'h_00;
	logic [15:0] ev = 16'h_0000;
	logic dr = 1'b0;
	logic bs;
	logic [7:0] q, txd, ae, cnt;
	logic [15:0] mb;
	logic [10:0] fn;
	logic txv, txr, enh, aee, res, err, sof, tk;
	int mismatches = 0;
	int compares = 0;
	always #5 clk = ~clk;
	always @(posedge clk) if (res === 1'b1) pulses <= pulses + 8'h_01;
	ufb_ctrl dut (.mclk_i(clk), .srst_i(rst), .sfr_addr_i(a), .sfr_wr_i(w),
		.sfr_rd_i(r), .sfr_wdata_i(d), .sfr_rdata_o(q), .bus_reset_i(br),
		.sof_i(sof), .frame_tick_i(tk), .frame_num_i(fn),
		.ep_event_i(ev), .tx_valid_o(txv), .tx_ready_i(txr),
		.tx_data_o(txd), .enhanced_o(enh), .address_enable_o(ae),
		.all_endpoints_enable_o(aee), .mode_bytes_o(mb), .resume_o(res),
		.ep2_buf_sel_o(bs), .cfg_error_o(err));
	ufb_link_model host (.mclk_i(clk), .srst_i(rst), .tx_valid_i(txv),
		.tx_ready_o(txr), .tx_data_i(txd), .stall_i(st), .sof_o(sof),
		.frame_tick_o(tk), .frame_num_o(fn), .count_o(cnt), .drop_i(dr));
	task automatic tally_and_finish;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic halt;
		mismatches++;
		tally_and_finish();
	endtask : halt
	task automatic put(input logic [7:0] ad, input logic [7:0] dv);
		a = ad;
		d = dv;
		w = 1'b1;
		@(negedge clk);
		w = 1'b0;
		@(negedge clk);
	endtask : put
	task automatic get(output logic [7:0] v);
		a = 8'h_FD;
		r = 1'b1;
		@(negedge clk);
		r = 1'b0;
		@(negedge clk);
		v = q;
	endtask : get
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			mismatches++;
		end
	endtask : chk
	task automatic settle;
		repeat (3) @(negedge clk);
	endtask : settle
	task automatic reset_dut;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
	endtask : reset_dut
	task automatic t_addr;
		chk("addr", 8'h_00, ae);
		chk("enh", 8'h_00, {7'h_00, enh});
		put(8'h_FC, 8'h_D0);
		put(8'h_FD, 8'h_85);
		put(8'h_FE, 8'h_11);
		put(8'h_FC, 8'h_D8);
		put(8'h_FD, 8'h_01);
		settle();
		chk("addr", 8'h_85, ae);
		chk("epen", 8'h_01, {7'h_00, aee});
		put(8'h_FC, 8'h_D0);
		put(8'h_FD, 8'h_05);
		settle();
		chk("epen", 8'h_00, {7'h_00, aee});
		br = 1'b1;
		@(negedge clk);
		br = 1'b0;
		settle();
		chk("addr", 8'h_80, ae);
	endtask : t_addr
	task automatic t_flags;
		logic [7:0] v;
		put(8'h_FC, 8'h_F4);
		get(v);
		chk("busrst", 8'h_40, v & 8'h_40);
		put(8'h_FC, 8'h_F4);
		get(v);
		chk("busrst", 8'h_00, v & 8'h_40);
		put(8'h_FC, 8'h_F3);
		put(8'h_FD, 8'h_12);
		settle();
		chk("mode", 8'h_00, mb[7:0]);
		put(8'h_FD, 8'h_4B);
		settle();
		chk("mode", 8'h_12, mb[7:0]);
		chk("mode", 8'h_4B, mb[15:8]);
		put(8'h_FC, 8'h_F6);
		settle();
		chk("resume", 8'h_01, pulses);
	endtask : t_flags
	task automatic t_event;
		logic [7:0] v;
		ev = 16'h_0004;
		@(negedge clk);
		ev = 16'h_0000;
		put(8'h_FC, 8'h_02);
		get(v);
		chk("select", 8'h_01, v);
		put(8'h_FC, 8'h_42);
		get(v);
		chk("laststat", 8'h_01, v);
		put(8'h_FC, 8'h_42);
		get(v);
		chk("laststat", 8'h_00, v);
		put(8'h_FC, 8'h_04);
		put(8'h_FC, 8'h_FA);
		settle();
		chk("bufsel", 8'h_01, {7'h_00, bs});
		put(8'h_FC, 8'h_84);
		get(v);
		chk("epstat", 8'h_20, v);
	endtask : t_event
	task automatic t_susp;
		logic [7:0] v;
		dr = 1'b1;
		repeat (120) @(negedge clk);
		put(8'h_FC, 8'h_F4);
		get(v);
		chk("suspend", 8'h_80, v & 8'h_80);
		put(8'h_FC, 8'h_F4);
		get(v);
		chk("suspend", 8'h_00, v & 8'h_80);
		dr = 1'b0;
		repeat (40) @(negedge clk);
		put(8'h_FC, 8'h_F4);
		get(v);
		chk("wakeup", 8'h_80, v & 8'h_80);
	endtask : t_susp
	task automatic t_frame;
		logic [7:0] lo;
		logic [7:0] hi;
		int i;
		for (i = 0; i < 40 && tk !== 1'b1; i++)
			@(negedge clk);
		if (i == 40) halt();
		@(negedge clk);
		put(8'h_FC, 8'h_F5);
		get(lo);
		get(hi);
		chk("frame", fn[7:0], lo);
		chk("frame", {5'h_00, fn[10:8]}, hi);
	endtask : t_frame
	task automatic t_buf;
		int i;
		put(8'h_FC, 8'h_F0);
		put(8'h_FD, 8'h_00);
		put(8'h_FD, 8'h_02);
		for (i = 0; i < 3; i++)
			put(8'h_FD, 8'h_30 + i[7:0]);
		settle();
		chk("count", 8'h_02, cnt);
		chk("byte", 8'h_31, host.got[1]);
		chk("err", 8'h_01, {7'h_00, err});
		reset_dut();
		st = 1'b1;
		put(8'h_FC, 8'h_F0);
		put(8'h_FD, 8'h_00);
		put(8'h_FD, 8'h_08);
		for (i = 0; i < 8; i++)
		begin
			if (i == 3) chk("err", 8'h_00, {7'h_00, err});
			put(8'h_FD, 8'h_40 + i[7:0]);
		end
		chk("err", 8'h_01, {7'h_00, err});
		st = 1'b0;
		for (i = 0; i < 50 && cnt < 8'h_04; i++)
			@(negedge clk);
		if (i == 50) halt();
		for (i = 0; i < 4; i++)
			chk("byte", 8'h_40 + i[7:0], host.got[i]);
	endtask : t_buf
	task automatic t_enh;
		reset_dut();
		chk("enh", 8'h_00, {7'h_00, enh});
		put(8'h_FC, 8'h_B3);
		put(8'h_FD, 8'h_1B);
		settle();
		chk("enh", 8'h_01, {7'h_00, enh});
		chk("err", 8'h_00, {7'h_00, err});
		put(8'h_FC, 8'h_B4);
		put(8'h_FD, 8'h_23);
		settle();
		chk("err", 8'h_01, {7'h_00, err});
	endtask : t_enh
	initial
	begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_addr();
		t_flags();
		t_event();
		t_susp();
		t_frame();
		t_buf();
		t_enh();
		tally_and_finish();
	end
endmodule : usb_fs_device_command_buffers_tb_top
`default_nettype wire
